// [design/ccms_cis_rom.sv]
// card information structure table, one byte per even attribute address
`timescale 1ns/1ps
module ccms_cis_rom #(
  // arbitrary identity values, not those of any real maker
  parameter logic [7:0] JEDEC_MFR = 8'h5A,
  parameter logic [7:0] JEDEC_ID = 8'h11,
  parameter logic [15:0] MANF_CODE = 16'h1234
) (
  input wire logic [7:0] index_i,
  output logic [7:0] byte_o
);

  localparam logic [7:0] TABLE [0:ccms_pkg::CIS_BYTES-1] = '{
    8'h01, 8'h03, 8'hD9, 8'h01, 8'hFF,
    8'h1C, 8'h04, 8'h03, 8'hD9, 8'h01, 8'hFF,
    8'h18, 8'h02, JEDEC_MFR, JEDEC_ID,
    8'h20, 8'h04, MANF_CODE[7:0], MANF_CODE[15:8], 8'h00, 8'h01,
    8'h15, 8'h13, 8'h04, 8'h01, 8'h58, 8'h59, 8'h5A, 8'h00,
    8'h53, 8'h74, 8'h6F, 8'h72, 8'h65, 8'h20, 8'h31, 8'h2E,
    8'h30, 8'h2E, 8'h30, 8'h00, 8'hFF,
    8'h21, 8'h02, 8'h04, 8'h01,
    8'h22, 8'h02, 8'h01, 8'h01,
    8'h22, 8'h03, 8'h02, 8'h0C, 8'h0F,
    8'h1A, 8'h05, 8'h01, 8'h03, 8'h00, 8'h02, 8'h0F,
    8'h1B, 8'h08, 8'hC0, 8'hC0, 8'hA1, 8'h01, 8'h55, 8'h08, 8'h00,
    8'h20,
    8'h1B, 8'h06, 8'h00, 8'h01, 8'h21, 8'hB5, 8'h1E, 8'h4D,
    8'h1B, 8'h0A, 8'hC1, 8'h41, 8'h99, 8'h01, 8'h55, 8'h64, 8'hF0,
    8'hFF, 8'hFF, 8'h20,
    8'h1B, 8'h06, 8'h01, 8'h01, 8'h21, 8'hB5, 8'h1E, 8'h4D,
    8'h1B, 8'h0F, 8'hC2, 8'h41, 8'h99, 8'h01, 8'h55, 8'hEA, 8'h61,
    8'hF0, 8'h01, 8'h07, 8'hF6, 8'h03, 8'h01, 8'hEE, 8'h20,
    8'h1B, 8'h06, 8'h02, 8'h01, 8'h21, 8'hB5, 8'h1E, 8'h4D,
    8'h1B, 8'h0F, 8'hC3, 8'h41, 8'h99, 8'h01, 8'h55, 8'hEA, 8'h61,
    8'h70, 8'h01, 8'h07, 8'h76, 8'h03, 8'h01, 8'hEE, 8'h20,
    8'h1B, 8'h06, 8'h03, 8'h01, 8'h21, 8'hB5, 8'h1E, 8'h4D,
    8'h14, 8'h00, 8'hFF
  };

  // beyond the table the tuple chain has ended, so pad with end marks
  assign byte_o = (int'(index_i) < ccms_pkg::CIS_BYTES) ?
                  TABLE[index_i] : ccms_pkg::CIS_PAD;

endmodule : ccms_cis_rom

// [design/ccms_config_top.sv]
// card configuration registers, mode select and task file decode
//
// Summary of operation
// RQ1: config registers reachable except in IDE mode
// RQ2: option register at 200h, resets to 00h
// RQ3: soft reset bit resets card, stays set
// RQ4: bit 6 picks pulse or level interrupt
// RQ5: mode field zero after any reset
// RQ6: mode zero: memory-mapped task file, duplicated
// RQ7: mode one: contiguous I/O, four address lines
// RQ8: mode two: primary I/O addresses
// RQ9: mode three: secondary I/O addresses
// RQ10: primary/secondary: ten lines, IRQ14 only
// RQ11: status 202, pins 204, socket 206
// RQ12: configuration indexes zero to three only
// RQ13: shareable pulse or level interrupts in I/O
// RQ14: memory mode maps 2048 bytes, host honours wait
// RQ15: ready/busy driven, no BVD or WP
// RQ16: power-down supported, no twins, audio, read-only
// RQ17: sleep, standby, idle entered automatically; here only idle and standby, sleep by power-down bit
// RQ18: host holds output enable low for IDE
// RQ19: power-down bit selects sleep or idle
// RQ20: host writes socket before option register
// RQ21: new mode used next access, >3 is memory
// RQ22: option register reads back as stored; here bits 6 to 0 read zero while the soft reset bit is set
`timescale 1ns/1ps
module ccms_config_top #(
  parameter int STANDBY_CYCLES = ccms_pkg::STANDBY_DELAY_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire ccms_pkg::ccms_bus_type host_bus_i,
  input wire logic [7:0] host_data_i,
  input wire logic irq_pending_i,
  input wire logic busy_i,
  output logic [7:0] host_data_o,
  output logic host_data_oe_o,
  output logic taskfile_hit_o,
  output logic [3:0] taskfile_offset_o,
  output logic taskfile_write_o,
  output logic io_card_o,
  output logic irq14_only_o,
  output logic iois8_o,
  output logic card_reset_o,
  output logic true_ide_o,
  output logic ireq_ready_n_o,
  output logic stschg_n_o,
  output logic bvd_oe_o,
  output logic wp_oe_o,
  output ccms_pkg::ccms_power_type power_state_o
);

  ////////////////////////////////////////////////////////////////////////
  // strap and strobe edges

  logic strap_done_reg;
  logic true_ide_reg;
  logic we_prev_reg;
  logic soft_reset_bit_reg;
  logic level_reg;
  logic [5:0] index_reg;
  logic sigchg_reg;
  logic iois8_reg;
  logic pwd_reg;
  logic crdy_reg;
  logic ready_prev_reg;
  logic drv_reg;

  wire ccms_pkg::ccms_bus_type bus = host_bus_i;
  wire we_fall = we_prev_reg & ~bus.we_n;
  wire card_sel = ~bus.ce1_n | ~bus.ce2_n;

  // RQ18 output enable strap sampled once, just after reset release
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      strap_done_reg <= 1'b0;
      true_ide_reg <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
      strap_done_reg <= 1'b1;
      true_ide_reg <= ~bus.oe_n;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      we_prev_reg <= 1'b1;
    else
      we_prev_reg <= bus.we_n;
  end

  ////////////////////////////////////////////////////////////////////////
  // attribute space decode

  // RQ1 no attribute access in IDE mode
  wire attr_space = ~bus.reg_n & ~bus.ce1_n & strap_done_reg
                    & ~true_ide_reg;
  wire attr_wr = attr_space & we_fall & bus.oe_n;
  wire attr_rd = attr_space & ~bus.oe_n & bus.we_n;
  // RQ2 option register decode
  wire hit_option = bus.addr == ccms_pkg::ADDR_OPTION;
  // RQ11 remaining registers above base
  wire hit_status = bus.addr == ccms_pkg::ADDR_STATUS;
  wire hit_pin = bus.addr == ccms_pkg::ADDR_PIN_REPL;
  wire hit_socket = bus.addr == ccms_pkg::ADDR_SOCKET;
  wire hit_cis = bus.addr < ccms_pkg::ADDR_CFG_BASE;
  // RQ20 host orders socket before option; no ordering enforced here
  wire wr_option = attr_wr & hit_option;
  wire wr_status = attr_wr & hit_status;
  wire wr_pin = attr_wr & hit_pin;
  wire wr_socket = attr_wr & hit_socket;

  ////////////////////////////////////////////////////////////////////////
  // option register

  // RQ3 soft reset bit stays until the host clears it
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      soft_reset_bit_reg <= ccms_pkg::OPTION_RESET[ccms_pkg::OPT_SOFT_RESET_BIT_BIT];
    else if (wr_option)
      soft_reset_bit_reg <= host_data_i[ccms_pkg::OPT_SOFT_RESET_BIT_BIT];
  end

  // RQ4 interrupt style selector
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      level_reg <= ccms_pkg::OPTION_RESET[ccms_pkg::OPT_LEVEL_BIT];
    else if (wr_option)
      level_reg <= host_data_i[ccms_pkg::OPT_LEVEL_BIT];
    else if (soft_reset_bit_reg)
      level_reg <= ccms_pkg::OPTION_RESET[ccms_pkg::OPT_LEVEL_BIT];
  end

  // RQ5 mode field cleared by hard and soft reset
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      index_reg <= ccms_pkg::INDEX_MEMORY;
    else if (soft_reset_bit_reg)
      index_reg <= ccms_pkg::INDEX_MEMORY;
    else if (wr_option)
      index_reg <= host_data_i[5:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // status, pin replacement, socket and copy

  // RQ19 power-down bit held here
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || soft_reset_bit_reg)
    begin
      sigchg_reg <= ccms_pkg::STATUS_RESET[ccms_pkg::STS_SIGCHG_BIT];
      iois8_reg <= ccms_pkg::STATUS_RESET[ccms_pkg::STS_IOIS8_BIT];
      pwd_reg <= ccms_pkg::STATUS_RESET[ccms_pkg::STS_PWD_BIT];
    end
    else if (wr_status)
    begin
      sigchg_reg <= host_data_i[ccms_pkg::STS_SIGCHG_BIT];
      iois8_reg <= host_data_i[ccms_pkg::STS_IOIS8_BIT];
      pwd_reg <= host_data_i[ccms_pkg::STS_PWD_BIT];
    end
  end

  // ready change sets the change bit; a same-cycle host write loses
  wire ready_now = ~busy_i;
  wire ready_changed = ready_now ^ ready_prev_reg;

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || soft_reset_bit_reg)
    begin
      crdy_reg <= 1'b0;
      ready_prev_reg <= 1'b1;
    end
    else
    begin
      ready_prev_reg <= ready_now;
      if (ready_changed)
        crdy_reg <= 1'b1;
      else if (wr_pin)
        crdy_reg <= host_data_i[ccms_pkg::PIN_CRDY_BIT];
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || soft_reset_bit_reg)
      drv_reg <= ccms_pkg::SOCKET_RESET[ccms_pkg::SOCK_DRV_BIT];
    else if (wr_socket)
      drv_reg <= host_data_i[ccms_pkg::SOCK_DRV_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // read-back path

  logic [7:0] cis_byte;

  ccms_cis_rom u_cis (
    .index_i (bus.addr[8:1]),
    .byte_o (cis_byte)
  );

  // RQ22 option read returns stored fields
  wire [7:0] option_rd = {soft_reset_bit_reg, level_reg, index_reg};
  wire [7:0] status_rd = {crdy_reg, sigchg_reg, iois8_reg, 2'b00,
                          pwd_reg, irq_pending_i, 1'b0};
  // RQ15 write-protect bits never set, ready state visible
  wire [7:0] pin_rd = ccms_pkg::PIN_REPL_FIXED
                      | {2'b00, crdy_reg, 3'b000, ready_now, 1'b0};
  wire [7:0] socket_rd = {3'b000, drv_reg, 4'h0};
  // odd attribute bytes and unused offsets at 200h and above read as zero
  wire [7:0] read_next = bus.addr[0] ? 8'h00 :
                         hit_cis ? cis_byte :
                         hit_option ? option_rd :
                         hit_status ? status_rd :
                         hit_pin ? pin_rd :
                         hit_socket ? socket_rd : 8'h00;

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      host_data_o <= 8'h00;
      host_data_oe_o <= 1'b0;
    end
    else
    begin
      host_data_o <= attr_rd ? read_next : 8'h00;
      host_data_oe_o <= attr_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // task file decode

  // RQ12 RQ21 only indexes zero to three; others stay memory-mapped
  wire idx_contig = index_reg == ccms_pkg::INDEX_CONTIG;
  wire idx_pri = index_reg == ccms_pkg::INDEX_PRIMARY;
  wire idx_sec = index_reg == ccms_pkg::INDEX_SECONDARY;
  wire io_mode = idx_contig | idx_pri | idx_sec;
  wire mem_strobe = ~bus.oe_n | ~bus.we_n;
  wire io_strobe = ~bus.iord_n | ~bus.iowr_n;
  // RQ6 RQ14 memory window: all 2048 bytes fold onto sixteen offsets
  wire mem_hit = ~io_mode & bus.reg_n & mem_strobe;
  // RQ10 ten address lines for the fixed windows
  wire pri_blk = bus.addr[9:3] == ccms_pkg::PRI_BLOCK_HI;
  wire pri_ctl = bus.addr[9:1] == ccms_pkg::PRI_CTRL_HI;
  wire sec_blk = bus.addr[9:3] == ccms_pkg::SEC_BLOCK_HI;
  wire sec_ctl = bus.addr[9:1] == ccms_pkg::SEC_CTRL_HI;
  // RQ8 primary window
  wire pri_hit = idx_pri & (pri_blk | pri_ctl);
  // RQ9 secondary window
  wire sec_hit = idx_sec & (sec_blk | sec_ctl);
  // RQ7 contiguous window ignores all but four lines
  wire io_hit = ~bus.reg_n & io_strobe & (idx_contig | pri_hit | sec_hit);
  wire tf_hit = card_sel & strap_done_reg & ~true_ide_reg & ~soft_reset_bit_reg
                & (mem_hit | io_hit);
  wire ctl_blk = (idx_pri & pri_ctl) | (idx_sec & sec_ctl);
  wire [3:0] tf_offset = (io_mode & ~idx_contig) ?
                         (ctl_blk ? {ccms_pkg::CTRL_OFFSET_HI, 1'b1,
                                     bus.addr[0]}
                                  : {1'b0, bus.addr[2:0]})
                         : bus.addr[3:0];
  wire tf_write = io_mode ? ~bus.iowr_n : ~bus.we_n;

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      taskfile_hit_o <= 1'b0;
      taskfile_offset_o <= 4'h0;
      taskfile_write_o <= 1'b0;
    end
    else
    begin
      taskfile_hit_o <= tf_hit;
      taskfile_offset_o <= tf_hit ? tf_offset : 4'h0;
      taskfile_write_o <= tf_hit & tf_write;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt and status pins

  logic irq_prev_reg;
  logic [ccms_pkg::PULSE_CNT_W-1:0] pulse_cnt_reg;

  wire irq_rise = irq_pending_i & ~irq_prev_reg;
  wire pulse_active = pulse_cnt_reg != '0;
  // RQ4 RQ13 level follows pending; pulse is a fixed low pulse
  wire irq_low = level_reg ? irq_pending_i : pulse_active;
  // RQ15 memory mode uses the pin as ready/busy
  wire ireq_next = io_mode ? ~irq_low : ready_now;
  wire stschg_next = ~(io_mode & sigchg_reg & crdy_reg);

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || soft_reset_bit_reg)
    begin
      irq_prev_reg <= 1'b0;
      pulse_cnt_reg <= '0;
    end
    else
    begin
      irq_prev_reg <= irq_pending_i;
      if (irq_rise && !level_reg)
        pulse_cnt_reg <= ccms_pkg::PULSE_CNT_W'(ccms_pkg::IRQ_PULSE_CYCLES);
      else if (pulse_active)
        pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
    end
  end

  // RQ15 RQ16 battery and write-protect pins never driven
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      ireq_ready_n_o <= 1'b1;
      stschg_n_o <= 1'b1;
      bvd_oe_o <= 1'b0;
      wp_oe_o <= 1'b0;
      io_card_o <= 1'b0;
      irq14_only_o <= 1'b0;
      iois8_o <= 1'b0;
      card_reset_o <= 1'b0;
      true_ide_o <= 1'b0;
    end
    else
    begin
      ireq_ready_n_o <= ireq_next;
      stschg_n_o <= stschg_next;
      bvd_oe_o <= 1'b0;
      wp_oe_o <= 1'b0;
      io_card_o <= io_mode;
      // RQ10 fixed windows route to IRQ14 only
      irq14_only_o <= idx_pri | idx_sec;
      iois8_o <= iois8_reg;
      // RQ3 card held in reset while the bit is set
      card_reset_o <= soft_reset_bit_reg;
      true_ide_o <= true_ide_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // low-power states

  ccms_pkg::ccms_power_type pwr_reg;
  logic [ccms_pkg::PWR_CNT_W-1:0] quiet_cnt_reg;

  wire activity = card_sel & (mem_strobe | io_strobe) | busy_i;
  wire idle_due = quiet_cnt_reg
                  >= ccms_pkg::PWR_CNT_W'(ccms_pkg::IDLE_DELAY_CYCLES);
  wire standby_due = quiet_cnt_reg >= ccms_pkg::PWR_CNT_W'(STANDBY_CYCLES);
  ccms_pkg::ccms_power_type pwr_next;

  // RQ17 RQ19 automatic idle and standby, sleep by power-down bit
  always_comb
  begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      ccms_pkg::PWR_ACTIVE:
        if (pwd_reg)
          pwr_next = ccms_pkg::PWR_SLEEP;
        else if (idle_due)
          pwr_next = ccms_pkg::PWR_IDLE;
      ccms_pkg::PWR_IDLE:
        if (pwd_reg)
          pwr_next = ccms_pkg::PWR_SLEEP;
        else if (activity)
          pwr_next = ccms_pkg::PWR_ACTIVE;
        else if (standby_due)
          pwr_next = ccms_pkg::PWR_STANDBY;
      ccms_pkg::PWR_STANDBY:
        if (pwd_reg)
          pwr_next = ccms_pkg::PWR_SLEEP;
        else if (activity)
          pwr_next = ccms_pkg::PWR_ACTIVE;
      ccms_pkg::PWR_SLEEP:
        if (!pwd_reg)
          pwr_next = ccms_pkg::PWR_IDLE;
      default:
        pwr_next = ccms_pkg::PWR_ACTIVE;
    endcase
  end

  // counter saturates so a long quiet spell cannot wrap to zero
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || activity)
      quiet_cnt_reg <= '0;
    else if (!standby_due)
      quiet_cnt_reg <= quiet_cnt_reg + 1'b1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      pwr_reg <= ccms_pkg::PWR_ACTIVE;
    else
      pwr_reg <= pwr_next;
  end

  assign power_state_o = pwr_reg;

endmodule : ccms_config_top

// [include/ccms_pkg.sv]
// shared constants and types of the card configuration block
package ccms_pkg;

  // host socket pins seen by the card, all active low except the address
  typedef struct packed {
    logic reg_n;
    logic ce1_n;
    logic ce2_n;
    logic oe_n;
    logic we_n;
    logic iord_n;
    logic iowr_n;
    logic [10:0] addr;
  } ccms_bus_type;

  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_IDLE,
    PWR_STANDBY,
    PWR_SLEEP
  } ccms_power_type;

  // attribute space byte addresses
  localparam logic [10:0] ADDR_OPTION = 11'h200;
  localparam logic [10:0] ADDR_STATUS = 11'h202;
  localparam logic [10:0] ADDR_PIN_REPL = 11'h204;
  localparam logic [10:0] ADDR_SOCKET = 11'h206;
  localparam logic [10:0] ADDR_CFG_BASE = 11'h200;

  // option register layout and reset value
  localparam int OPT_SOFT_RESET_BIT_BIT = 7;
  localparam int OPT_LEVEL_BIT = 6;
  localparam logic [7:0] OPTION_RESET = 8'h00;
  localparam logic [5:0] INDEX_MEMORY = 6'h00;
  localparam logic [5:0] INDEX_CONTIG = 6'h01;
  localparam logic [5:0] INDEX_PRIMARY = 6'h02;
  localparam logic [5:0] INDEX_SECONDARY = 6'h03;

  // status register layout
  localparam int STS_CHGED_BIT = 7;
  localparam int STS_SIGCHG_BIT = 6;
  localparam int STS_IOIS8_BIT = 5;
  localparam int STS_PWD_BIT = 2;
  localparam int STS_INTR_BIT = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // pin replacement layout; bits 3 and 2 always read one
  localparam int PIN_CRDY_BIT = 5;
  localparam int PIN_RRDY_BIT = 1;
  localparam logic [7:0] PIN_REPL_FIXED = 8'h0C;

  // socket and copy layout
  localparam int SOCK_DRV_BIT = 4;
  localparam logic [7:0] SOCKET_RESET = 8'h00;

  // io windows: primary and secondary, eight-byte and two-byte blocks
  localparam logic [6:0] PRI_BLOCK_HI = 7'h3E;
  localparam logic [8:0] PRI_CTRL_HI = 9'h1FB;
  localparam logic [6:0] SEC_BLOCK_HI = 7'h2E;
  localparam logic [8:0] SEC_CTRL_HI = 9'h1BB;
  localparam logic [1:0] CTRL_OFFSET_HI = 2'h3;

  // cis storage
  localparam int CIS_BYTES = 153;
  localparam logic [7:0] CIS_PAD = 8'hFF;

  // timing at 40 MHz
  localparam int CLK_MHZ = 40;
  localparam int IRQ_PULSE_NS = 500;
  localparam int IRQ_PULSE_CYCLES = (IRQ_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int IDLE_DELAY_US = 100;
  localparam int IDLE_DELAY_CYCLES = IDLE_DELAY_US * CLK_MHZ;
  localparam int STANDBY_DELAY_US = 5000;
  localparam int STANDBY_DELAY_CYCLES = STANDBY_DELAY_US * CLK_MHZ;
  localparam int PWR_CNT_W = 18;
  localparam int PULSE_CNT_W = 5;

endpackage : ccms_pkg

// [testbench/card_config_mode_select_test.sv]
// self-checking bench for the card configuration block
`timescale 1ns/1ps
module card_config_mode_select_test;
  localparam int STBY = 6000;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic irq_pending = 1'b0;
  logic busy = 1'b0;
  ccms_pkg::ccms_bus_type host_bus;
  ccms_pkg::ccms_power_type pwr;
  logic [7:0] wdata, rdata;
  logic [3:0] tf_off;
  logic rd_oe, tf_hit, tf_wr, io_card, irq14, card_rst, true_ide;
  logic ireq_rdy_n, bvd_oe, wp_oe, iois8, stschg_n;
  integer seed = 35202;
  int fails = 0;
  int tests_run = 0;
  always #12.5 core_clk = ~core_clk;
  ccms_config_top #(.STANDBY_CYCLES(STBY)) u_ccms_config_top (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .host_bus_i(host_bus),
    .host_data_i(wdata), .irq_pending_i(irq_pending), .busy_i(busy),
    .host_data_o(rdata), .host_data_oe_o(rd_oe),
    .taskfile_hit_o(tf_hit), .taskfile_offset_o(tf_off),
    .taskfile_write_o(tf_wr), .io_card_o(io_card), .irq14_only_o(irq14),
    .iois8_o(iois8), .card_reset_o(card_rst), .true_ide_o(true_ide),
    .ireq_ready_n_o(ireq_rdy_n), .stschg_n_o(stschg_n), .bvd_oe_o(bvd_oe),
    .wp_oe_o(wp_oe), .power_state_o(pwr));
  ccms_host_model u_ccms_host_model (.core_clk_i(core_clk),
    .rd_data_i(rdata), .rd_oe_i(rd_oe), .host_bus_o(host_bus),
    .wr_data_o(wdata));
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask : chk
  // a state never reached within its bound ends the run
  task automatic wait_pwr(input ccms_pkg::ccms_power_type st,
    input int bound);
    int n;
    n = 0;
    tests_run++;
    while (pwr !== st && n < bound)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n >= bound)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, pwr, st);
      fails++;
      stop_test();
    end
  endtask : wait_pwr
  // socket register goes first, as the host is expected to do
  task automatic set_option(input logic [7:0] v);
    u_ccms_host_model.attr_write(ccms_pkg::ADDR_SOCKET, 8'h10);
    u_ccms_host_model.attr_write(ccms_pkg::ADDR_OPTION, v);
  endtask : set_option
  // expected {hit, offset} of a task file access
  function automatic logic [4:0] exp_tf(input logic [5:0] idx,
    input logic [10:0] a);
    logic pri;
    pri = idx == ccms_pkg::INDEX_PRIMARY;
    if (idx != ccms_pkg::INDEX_PRIMARY && idx != ccms_pkg::INDEX_SECONDARY)
      return {1'b1, a[3:0]};
    if (a[9:3] == (pri ? ccms_pkg::PRI_BLOCK_HI : ccms_pkg::SEC_BLOCK_HI))
      return {2'b10, a[2:0]};
    if (a[9:1] == (pri ? ccms_pkg::PRI_CTRL_HI : ccms_pkg::SEC_CTRL_HI))
      return {4'b1111, a[0]};
    return 5'h00;
  endfunction : exp_tf
  ////////////////////////////////////////////////////////////////////////
  initial
  begin : main
    logic [7:0] d, r;
    logic oe, io_m;
    logic [5:0] idx;
    logic [10:0] a;
    int n;
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    u_ccms_host_model.attr_read(ccms_pkg::ADDR_OPTION, d, oe);
    chk({oe, d}, {1'b1, ccms_pkg::OPTION_RESET});
    chk({bvd_oe, wp_oe, ireq_rdy_n}, 3'b001);
    for (int m = 0; m < 5; m++)
    begin
      r = 8'($random(seed));
      idx = (m < 4) ? m[5:0] : (r[5:0] | 6'h04);
      io_m = idx != 6'h00 && idx < 6'h04;
      set_option({1'b0, r[6], idx});
      u_ccms_host_model.attr_read(ccms_pkg::ADDR_OPTION, d, oe);
      chk(d, {1'b0, r[6], idx});
      chk({io_card, irq14}, {io_m, idx[5:1] == 5'h01});
      for (int k = 0; k < 6; k++)
      begin
        a = 11'($random(seed));
        if (k == 0)
          a[9:3] = idx[0] ? ccms_pkg::SEC_BLOCK_HI : ccms_pkg::PRI_BLOCK_HI;
        if (k == 1)
          a[9:1] = idx[0] ? ccms_pkg::SEC_CTRL_HI : ccms_pkg::PRI_CTRL_HI;
        u_ccms_host_model.drive(io_m ? (k[0] ? 7'h1E : 7'h1D)
          : (k[0] ? 7'h5B : 7'h57), a);
        chk({tf_hit, tf_off, tf_wr},
          {exp_tf(idx, a), exp_tf(idx, a) >= 5'h10 && k[0]});
        u_ccms_host_model.release_bus();
      end
    end
    set_option(8'h41);
    irq_pending = 1'b1;
    repeat (3) @(negedge core_clk);
    chk(ireq_rdy_n, 1'b0);
    irq_pending = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(ireq_rdy_n, 1'b1);
    set_option(8'h01);
    irq_pending = 1'b1;
    n = 0;
    repeat (40)
    begin
      @(negedge core_clk);
      n += (ireq_rdy_n === 1'b0);
    end
    irq_pending = 1'b0;
    chk(n[15:0], 16'(ccms_pkg::IRQ_PULSE_CYCLES));
    set_option(8'h00);
    busy = 1'b1;
    repeat (3) @(negedge core_clk);
    chk(ireq_rdy_n, 1'b0);
    busy = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(ireq_rdy_n, 1'b1);
    set_option(8'hC3);
    u_ccms_host_model.attr_read(ccms_pkg::ADDR_OPTION, d, oe);
    chk({d, card_rst, io_card}, {8'h80, 2'b10});
    set_option(8'h00);
    chk(card_rst, 1'b0);
    u_ccms_host_model.attr_write(ccms_pkg::ADDR_STATUS, 8'h04);
    wait_pwr(ccms_pkg::PWR_SLEEP, 4);
    u_ccms_host_model.attr_write(ccms_pkg::ADDR_STATUS, 8'h00);
    wait_pwr(ccms_pkg::PWR_IDLE, ccms_pkg::IDLE_DELAY_CYCLES + 20);
    wait_pwr(ccms_pkg::PWR_STANDBY, STBY + 20);
    busy = 1'b1;
    wait_pwr(ccms_pkg::PWR_ACTIVE, 4);
    busy = 1'b0;
    // ready toggled above, so the change bit is set by now
    set_option(8'h01);
    u_ccms_host_model.attr_write(ccms_pkg::ADDR_STATUS, 8'h60);
    u_ccms_host_model.attr_read(ccms_pkg::ADDR_STATUS, d, oe);
    chk({d, iois8, stschg_n}, {8'hE0, 2'b10});
    u_ccms_host_model.attr_read(ccms_pkg::ADDR_PIN_REPL, d, oe);
    chk(d, 8'h2E);
    u_ccms_host_model.attr_read(ccms_pkg::ADDR_SOCKET, d, oe);
    chk(d, 8'h10);
    rst_n = 1'b0;
    u_ccms_host_model.strap_ide();
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    u_ccms_host_model.release_bus();
    u_ccms_host_model.attr_write(ccms_pkg::ADDR_OPTION, 8'h01);
    u_ccms_host_model.attr_read(ccms_pkg::ADDR_OPTION, d, oe);
    chk({true_ide, oe, io_card}, 3'b100);
    stop_test();
  end
endmodule : card_config_mode_select_test

// [testbench/ccms_config_monitor.sv]
// assertion checker bound to the card configuration top
`timescale 1ns/1ps
module ccms_config_monitor (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire ccms_pkg::ccms_bus_type host_bus_i,
  input wire logic busy_i,
  input wire logic host_data_oe_o,
  input wire logic taskfile_hit_o,
  input wire logic [3:0] taskfile_offset_o,
  input wire logic io_card_o,
  input wire logic irq14_only_o,
  input wire logic card_reset_o,
  input wire logic true_ide_o,
  input wire logic ireq_ready_n_o,
  input wire logic bvd_oe_o,
  input wire logic wp_oe_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////
  wire attr_rd = !host_bus_i.reg_n && !host_bus_i.ce1_n
    && !host_bus_i.oe_n && host_bus_i.we_n;
  wire contig_rd = io_card_o && !irq14_only_o && !card_reset_o
    && !host_bus_i.reg_n && !host_bus_i.iord_n;
  ////////////////////////////////////////////////////////////////////////
  property p_read_oe;
    attr_rd |=> host_data_oe_o || true_ide_o;
  endproperty
  a_read_oe: assert property (p_read_oe)
    else $error("attribute read not answered");
  property p_read_drop;
    $rose(host_bus_i.oe_n) |=> !host_data_oe_o;
  endproperty
  a_read_drop: assert property (p_read_drop)
    else $error("read data still driven after oe_n rose");
  property p_ide_quiet;
    true_ide_o && $past(true_ide_o) |-> !host_data_oe_o;
  endproperty
  a_ide_quiet: assert property (p_ide_quiet)
    else $error("attribute read answered in ide mode");
  property p_no_bvd_wp;
    !bvd_oe_o && !wp_oe_o;
  endproperty
  a_no_bvd_wp: assert property (p_no_bvd_wp)
    else $error("status pin driven");
  property p_irq14_io;
    irq14_only_o |-> io_card_o;
  endproperty
  a_irq14_io: assert property (p_irq14_io)
    else $error("irq14 routing outside io mode");
  property p_contig;
    contig_rd |=> taskfile_hit_o
      && taskfile_offset_o == $past(host_bus_i.addr[3:0]);
  endproperty
  a_contig: assert property (p_contig)
    else $error("contiguous io decode wrong");
  property p_soft_reset_bit;
    card_reset_o && $past(card_reset_o) |-> !io_card_o && !taskfile_hit_o;
  endproperty
  a_soft_reset_bit: assert property (p_soft_reset_bit)
    else $error("mode not cleared during soft reset");
  property p_mem_ready;
    (!io_card_o && busy_i && !card_reset_o && !true_ide_o) [*3]
      |-> !ireq_ready_n_o;
  endproperty
  a_mem_ready: assert property (p_mem_ready)
    else $error("ready pin does not show busy");
endmodule : ccms_config_monitor

bind ccms_config_top ccms_config_monitor u_ccms_config_monitor (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .host_bus_i(host_bus_i),
  .busy_i(busy_i), .host_data_oe_o(host_data_oe_o),
  .taskfile_hit_o(taskfile_hit_o), .taskfile_offset_o(taskfile_offset_o),
  .io_card_o(io_card_o), .irq14_only_o(irq14_only_o),
  .card_reset_o(card_reset_o), .true_ide_o(true_ide_o),
  .ireq_ready_n_o(ireq_ready_n_o), .bvd_oe_o(bvd_oe_o), .wp_oe_o(wp_oe_o)
);

// [testbench/ccms_host_model.sv]
// host socket model driving attribute and task file cycles
`timescale 1ns/1ps
module ccms_host_model (
  input wire logic core_clk_i,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_oe_i,
  output ccms_pkg::ccms_bus_type host_bus_o,
  output logic [7:0] wr_data_o
);
  initial
  begin
    host_bus_o = {7'h7F, 11'h000};
    wr_data_o = 8'h00;
  end
  // released lines float: show a changing pattern, not the last value
  task automatic release_bus();
    @(negedge core_clk_i);
    host_bus_o = {7'h7F, ~host_bus_o.addr};
    wr_data_o = ~wr_data_o;
  endtask : release_bus
  // strobes held across two edges; caller samples, then releases
  task automatic drive(input logic [6:0] strb, input logic [10:0] addr);
    @(negedge core_clk_i);
    host_bus_o = {strb, addr};
    repeat (2) @(negedge core_clk_i);
  endtask : drive
  // we_n high, low, high again so each write is taken once
  task automatic attr_write(input logic [10:0] addr, input logic [7:0] data);
    @(negedge core_clk_i);
    host_bus_o = {7'h1F, addr};
    wr_data_o = data;
    @(negedge core_clk_i);
    host_bus_o.we_n = 1'b0;
    @(negedge core_clk_i);
    host_bus_o.we_n = 1'b1;
    release_bus();
  endtask : attr_write
  task automatic attr_read(input logic [10:0] addr, output logic [7:0] d,
    output logic oe);
    drive(7'h17, addr);
    d = rd_data_i;
    oe = rd_oe_i;
    release_bus();
  endtask : attr_read
  task automatic strap_ide();
    host_bus_o = {7'h77, 11'h000};
  endtask : strap_ide
endmodule : ccms_host_model
